//--- lpmc_ctrl.sv
`timescale 1ns/1ps
module lpmc_ctrl #(
    parameter int BOR_CYCLES = 4
) (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  irq_pending,
    input  wire logic [15:0]           program_counter,
    input  wire logic                  wake_reset_pin,
    input  wire logic                  wake_power_cycle,
    input  wire logic                  wake_io,
    input  wire logic                  wake_rtc,
    input  wire logic                  rtc_enable,
    output lpmc_pkg::lpmc_gate_t       gates,
    output logic                       core_supply_en,
    output logic                       rtc_run,
    output logic                       brownout_reset,
    output logic                       pin_lock,
    output logic      [15:0]           boot_start_addr,
    output logic                       irq_entry
);

    // ************************************************************
    // State and registers
    // ************************************************************
    lpmc_pkg::lpmc_state_t state_reg, state_next;
    logic [15:0] status_word_reg, status_word_next;
    logic [15:0] stacked_sw_reg, stacked_pc_reg;
    logic [3:0]  clk_cfg_reg;
    logic        reg_off_reg, deep35_reg, unlocked_reg;
    logic        pin_lock_reg, wake_flag_reg;
    logic [15:0] reset_cause_reg;
    logic [7:0]  bor_cnt_reg;
    logic        was35_reg;

    // ************************************************************
    // APB decode
    // ************************************************************
    wire acc      = psel && penable;
    wire wr       = acc && pwrite;
    wire rd       = acc && !pwrite;
    wire hit_sw   = paddr == lpmc_pkg::ADDR_STATUS_WORD;
    wire hit_cfg  = paddr == lpmc_pkg::ADDR_CLK_CFG;
    wire hit_pmm  = paddr == lpmc_pkg::ADDR_PWR_MGMT_CTL;
    wire hit_ds   = paddr == lpmc_pkg::ADDR_DEEP_SLEEP;
    wire hit_rc   = paddr == lpmc_pkg::ADDR_RESET_CAUSE;
    wire hit_st   = paddr == lpmc_pkg::ADDR_STATE;
    wire hit_ssw  = paddr == lpmc_pkg::ADDR_STACKED_SW;
    wire hit_spc  = paddr == lpmc_pkg::ADDR_STACKED_PC;
    wire hit_stb  = paddr == lpmc_pkg::ADDR_CTL_STROBE;
    wire mapped   = hit_sw | hit_cfg | hit_pmm | hit_ds | hit_rc | hit_st | hit_ssw
                  | hit_spc | hit_stb;
    wire run      = state_reg == lpmc_pkg::ST_RUN;
    wire bus_ok   = mapped && run;

    assign pready  = 1'b1;
    assign pslverr = acc && !bus_ok;

    // ************************************************************
    // Mode decode
    // ************************************************************
    wire proc_stop = status_word_reg[lpmc_pkg::POS_PROC_STOP];
    wire osc_stop  = status_word_reg[lpmc_pkg::POS_OSC_STOP];
    wire cg_lo     = status_word_reg[lpmc_pkg::POS_CG_LO];
    wire cg_hi     = status_word_reg[lpmc_pkg::POS_CG_HI];
    wire global_irq_enable       = status_word_reg[lpmc_pkg::POS_GIE];
    wire all_bits  = proc_stop && osc_stop && cg_lo && cg_hi;
    wire sleeping  = proc_stop || osc_stop || cg_lo || cg_hi;
    wire sub_gate  = clk_cfg_reg[lpmc_pkg::POS_SUB_MAIN_CLOCK_GATE];
    wire src_aux   = clk_cfg_reg[lpmc_pkg::POS_OSC_AUX];
    wire src_main  = clk_cfg_reg[lpmc_pkg::POS_OSC_MAIN];
    wire src_sub   = clk_cfg_reg[lpmc_pkg::POS_OSC_SUB];

    // Each bit but cg_lo gates on its own, so listed modes fall out of it
    wire proc_on   = run && !proc_stop;
    wire aux_on    = run && !osc_stop;
    wire sub_on    = run && !cg_hi && !sub_gate;
    wire osc_on    = run && !osc_stop &&
                     ((src_aux && aux_on) || (src_main && proc_on) ||
                      (src_sub && sub_on));
    // Bias stays up for a main source even while the processor sleeps, unless cg_hi is set
    wire bias_on   = run && !cg_hi &&
                     (osc_on || src_main || (src_sub && sub_on));

    assign gates.proc_clk_en = proc_on;
    assign gates.main_clk_en = proc_on;
    assign gates.aux_clk_en  = aux_on;
    assign gates.sub_clk_en  = sub_on;
    assign gates.osc_en      = osc_on;
    assign gates.osc_bias_en = bias_on;

    // Regulator-off needs the password first
    wire enter_deep = run && all_bits && reg_off_reg;
    wire deep_wake  = wake_reset_pin || wake_power_cycle || wake_io ||
                      (was35_reg && wake_rtc);
    wire stb_wr     = wr && bus_ok && hit_stb;
    wire all_bits_deep = all_bits && reg_off_reg;
    wire irq_take   = run && sleeping && !all_bits_deep && global_irq_enable && irq_pending;
    wire return_from_interrupt       = stb_wr && pwdata[lpmc_pkg::POS_STB_RETURN_FROM_INTERRUPT];
    wire irq_sw     = stb_wr && pwdata[lpmc_pkg::POS_STB_IRQ];
    wire do_entry   = irq_take || irq_sw;

    assign core_supply_en  = state_reg != lpmc_pkg::ST_DEEP;
    // Rtc stays off through the brownout that follows the all-off level
    assign rtc_run         = rtc_enable && (run || was35_reg);
    assign brownout_reset  = state_reg == lpmc_pkg::ST_WAKE_BOR;
    assign pin_lock        = pin_lock_reg;
    assign boot_start_addr = lpmc_pkg::RESET_VECTOR_ADDR;
    assign irq_entry       = do_entry;

    // ************************************************************
    // Next values
    // ************************************************************
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            lpmc_pkg::ST_RUN:      if (enter_deep) state_next = lpmc_pkg::ST_DEEP;
            lpmc_pkg::ST_DEEP:     if (deep_wake) state_next = lpmc_pkg::ST_WAKE_BOR;
            lpmc_pkg::ST_WAKE_BOR: begin
                if (bor_cnt_reg == 8'(BOR_CYCLES - 1)) state_next = lpmc_pkg::ST_RUN;
            end
            default:               state_next = lpmc_pkg::ST_RUN;
        endcase
    end

    always_comb begin
        status_word_next = status_word_reg;
        if (wr && bus_ok && hit_sw) begin
            status_word_next = pwdata[15:0];
        end
        if (return_from_interrupt) begin
            status_word_next = stacked_sw_reg;
        end
        if (do_entry) begin
            status_word_next[lpmc_pkg::POS_PROC_STOP] = 1'b0;
            status_word_next[lpmc_pkg::POS_CG_HI]     = 1'b0;
            status_word_next[lpmc_pkg::POS_OSC_STOP]  = 1'b0;
            status_word_next[lpmc_pkg::POS_GIE]       = 1'b0;
        end
    end

    // ************************************************************
    // Flops
    // ************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= lpmc_pkg::ST_RUN;
            bor_cnt_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            bor_cnt_reg <= (state_reg == lpmc_pkg::ST_WAKE_BOR) ? bor_cnt_reg + 8'h01 : 8'h00;
        end
    end

    // Core registers lose content whenever the supply is gone
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_word_reg <= lpmc_pkg::SW_RESET;
            stacked_sw_reg  <= lpmc_pkg::SW_RESET;
            stacked_pc_reg  <= 16'h0000;
            clk_cfg_reg     <= lpmc_pkg::CLK_CFG_RESET;
            reg_off_reg     <= 1'b0;
            deep35_reg      <= 1'b0;
            unlocked_reg    <= 1'b0;
        end else if (!run) begin
            status_word_reg <= lpmc_pkg::SW_RESET;
            stacked_sw_reg  <= lpmc_pkg::SW_RESET;
            stacked_pc_reg  <= 16'h0000;
            clk_cfg_reg     <= lpmc_pkg::CLK_CFG_RESET;
            reg_off_reg     <= 1'b0;
            unlocked_reg    <= 1'b0;
            deep35_reg      <= 1'b0;
        end else begin
            status_word_reg <= status_word_next;
            if (do_entry) begin
                stacked_sw_reg <= status_word_reg;
                stacked_pc_reg <= program_counter;
            end else if (wr && hit_ssw) begin
                stacked_sw_reg <= pwdata[15:0];
            end
            if (wr && hit_cfg) clk_cfg_reg <= pwdata[3:0];
            if (wr && hit_pmm) begin
                unlocked_reg <= pwdata[15:8] == lpmc_pkg::PMM_PASSWORD;
                if (unlocked_reg) begin
                    reg_off_reg <= pwdata[lpmc_pkg::POS_REG_OFF];
                    deep35_reg  <= pwdata[lpmc_pkg::POS_DEEP_SEL35];
                end
            end
        end
    end

    // Flags living outside the switched core domain
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_lock_reg    <= 1'b0;
            wake_flag_reg   <= 1'b0;
            reset_cause_reg <= 16'h0000;
            was35_reg       <= 1'b0;
        end else begin
            if (enter_deep) begin
                pin_lock_reg <= 1'b1;
                was35_reg    <= deep35_reg;
            end else if (wr && bus_ok && hit_ds && !pwdata[lpmc_pkg::POS_PIN_LOCK]) begin
                pin_lock_reg <= 1'b0;
            end
            if (state_reg == lpmc_pkg::ST_DEEP && deep_wake) begin
                wake_flag_reg   <= 1'b1;
                reset_cause_reg <= lpmc_pkg::RESET_CAUSE_DEEP;
            end else if (wr && bus_ok && hit_ds && !pwdata[lpmc_pkg::POS_WAKE_FLAG]) begin
                wake_flag_reg <= 1'b0;
            end else if (rd && bus_ok && hit_rc) begin
                reset_cause_reg <= 16'h0000;
            end
        end
    end

    // ************************************************************
    // Read data
    // ************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= 32'h0000_0000;
            if (hit_sw)  prdata <= {16'h0000, status_word_reg};
            if (hit_cfg) prdata <= {28'h0000000, clk_cfg_reg};
            if (hit_pmm) prdata <= {30'h0, deep35_reg, reg_off_reg};
            if (hit_ds)  prdata <= {30'h0, wake_flag_reg, pin_lock_reg};
            if (hit_rc)  prdata <= {16'h0000, reset_cause_reg};
            if (hit_st)  prdata <= {26'h0, gates};
            if (hit_ssw) prdata <= {16'h0000, stacked_sw_reg};
            if (hit_spc) prdata <= {16'h0000, stacked_pc_reg};
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    a_active_clocks: assert property (@(posedge clk) disable iff (rst)
        (run && status_word_reg[7:4] == 4'h0) |-> (gates.proc_clk_en && gates.aux_clk_en))
        else $error("active state clocks wrong");
    a_level4_off: assert property (@(posedge clk) disable iff (rst)
        (all_bits) |-> (gates == 6'h00))
        else $error("level 4 clocks not stopped");
    a_level2_sub: assert property (@(posedge clk) disable iff (rst)
        (cg_hi && proc_stop) |-> (!gates.sub_clk_en && !gates.main_clk_en))
        else $error("level 2/3 gating wrong");
    a_deep_entry: assert property (@(posedge clk) disable iff (rst)
        enter_deep |=> (!core_supply_en && pin_lock))
        else $error("deep entry not taken");
    a_bor_pulse: assert property (@(posedge clk) disable iff (rst)
        (state_reg == lpmc_pkg::ST_DEEP && deep_wake) |=> brownout_reset[*4])
        else $error("brownout too short");
    a_wake_flag: assert property (@(posedge clk) disable iff (rst)
        (state_reg == lpmc_pkg::ST_DEEP && deep_wake) |=>
            (wake_flag_reg && reset_cause_reg == 16'h0008))
        else $error("wake flag not set");
    a_irq_clear: assert property (@(posedge clk) disable iff (rst)
        (run && do_entry && !return_from_interrupt) |=> (!proc_stop && !cg_hi && !osc_stop))
        else $error("entry did not clear bits");
    a_irq_push: assert property (@(posedge clk) disable iff (rst)
        (run && do_entry) |=> (stacked_sw_reg == $past(status_word_reg)))
        else $error("status word not pushed");

endmodule : lpmc_ctrl

//--- lpmc_pkg.sv
package lpmc_pkg;

    // ************************************************************
    // Status word layout
    // ************************************************************
    localparam int SW_W          = 16;
    localparam int POS_GIE       = 3;
    localparam int POS_PROC_STOP = 4;
    localparam int POS_OSC_STOP  = 5;
    localparam int POS_CG_LO     = 6;
    localparam int POS_CG_HI     = 7;

    // ************************************************************
    // Register map (APB byte addresses)
    // ************************************************************
    localparam logic [7:0] ADDR_STATUS_WORD  = 8'h00;
    localparam logic [7:0] ADDR_CLK_CFG      = 8'h04;
    localparam logic [7:0] ADDR_PWR_MGMT_CTL = 8'h08;
    localparam logic [7:0] ADDR_DEEP_SLEEP   = 8'h0C;
    localparam logic [7:0] ADDR_RESET_CAUSE  = 8'h10;
    localparam logic [7:0] ADDR_STATE        = 8'h14;
    localparam logic [7:0] ADDR_STACKED_SW   = 8'h18;
    localparam logic [7:0] ADDR_STACKED_PC   = 8'h1C;
    localparam logic [7:0] ADDR_CTL_STROBE   = 8'h20;

    // Power control fields
    localparam int          POS_REG_OFF     = 0;
    localparam int          POS_DEEP_SEL35  = 1;
    localparam logic [7:0]  PMM_PASSWORD    = 8'hA5;
    localparam int          POS_PIN_LOCK    = 0;
    localparam int          POS_WAKE_FLAG   = 1;
    // Clock config fields: source selections and sub-main gate
    localparam int          POS_SUB_MAIN_CLOCK_GATE  = 0;
    localparam int          POS_OSC_AUX     = 1;
    localparam int          POS_OSC_MAIN    = 2;
    localparam int          POS_OSC_SUB     = 3;
    // Strobe register bits
    localparam int          POS_STB_IRQ     = 0;
    localparam int          POS_STB_RETURN_FROM_INTERRUPT    = 1;

    localparam logic [15:0] RESET_CAUSE_DEEP  = 16'h0008;
    localparam logic [15:0] RESET_VECTOR_ADDR = 16'hFFFE;
    localparam logic [15:0] SW_RESET          = 16'h0000;
    localparam logic [3:0]  CLK_CFG_RESET     = 4'h0;

    typedef enum {
        ST_RUN,
        ST_DEEP,
        ST_WAKE_BOR
    } lpmc_state_t;

    typedef struct packed {
        logic proc_clk_en;
        logic main_clk_en;
        logic aux_clk_en;
        logic sub_clk_en;
        logic osc_en;
        logic osc_bias_en;
    } lpmc_gate_t;

endpackage : lpmc_pkg

//--- lpmc_core_model.sv
`timescale 1ns/1ps
// ********
// Core, interrupt source and wake pin model
// ********
module lpmc_core_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        irq_req,
    input  wire logic [15:0] pc_val,
    input  wire logic        wake_req,
    input  wire logic [1:0]  wake_sel,
    input  wire logic        irq_entry,
    output logic             irq_pending,
    output logic      [15:0] program_counter,
    output logic             wake_reset_pin,
    output logic             wake_power_cycle,
    output logic             wake_io,
    output logic             wake_rtc,
    output int               entry_count
);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_pending     <= 1'b0;
            program_counter <= 16'h0000;
            entry_count     <= 0;
        end else if (irq_req) begin
            irq_pending     <= 1'b1;
            program_counter <= pc_val;
        end else if (irq_pending && irq_entry) begin
            irq_pending     <= 1'b0;
            // Counter moves on once taken, so a late push sees a wrong value
            program_counter <= ~program_counter;
            entry_count     <= entry_count + 1;
        end
    end
    // Wake lines pulse only while requested
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            {wake_rtc, wake_io, wake_power_cycle, wake_reset_pin} <= 4'h0;
        else
            {wake_rtc, wake_io, wake_power_cycle, wake_reset_pin} <=
                wake_req ? (4'h1 << wake_sel) : 4'h0;
    end
endmodule : lpmc_core_model

//--- tb_low_power_mode_control.sv
`timescale 1ns/1ps
module tb_low_power_mode_control;
    localparam int BOR = 4;
    logic                 clk, rst, psel, penable, pwrite, pready, pslverr;
    logic [7:0]           paddr;
    logic [31:0]          pwdata, prdata;
    logic                 irq_pending, irq_req, irq_entry, wake_req, rtc_enable;
    logic [1:0]           wake_sel;
    logic [15:0]          program_counter, pc_val, boot_start_addr;
    logic                 wake_reset_pin, wake_power_cycle, wake_io, wake_rtc;
    logic                 core_supply_en, rtc_run, brownout_reset, pin_lock;
    lpmc_pkg::lpmc_gate_t gates;
    wire logic [5:0]      gates_bits = gates;
    int                   entry_count, err_count, check_count, seed;
    logic [32:0]          exp_q[$];
    logic [32:0]          mon_e;
    logic [3:0]           pats [6] = '{4'h0, 4'h1, 4'h5, 4'h9, 4'hD, 4'hF};

    lpmc_ctrl #(.BOR_CYCLES(BOR)) lpmc_ctrl_i (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq_pending(irq_pending), .program_counter(program_counter),
        .wake_reset_pin(wake_reset_pin), .wake_power_cycle(wake_power_cycle),
        .wake_io(wake_io), .wake_rtc(wake_rtc), .rtc_enable(rtc_enable), .gates(gates),
        .core_supply_en(core_supply_en), .rtc_run(rtc_run), .brownout_reset(brownout_reset),
        .pin_lock(pin_lock), .boot_start_addr(boot_start_addr), .irq_entry(irq_entry));
    lpmc_core_model lpmc_core_model_i (
        .clk(clk), .rst(rst), .irq_req(irq_req), .pc_val(pc_val), .wake_req(wake_req),
        .wake_sel(wake_sel), .irq_entry(irq_entry), .irq_pending(irq_pending),
        .program_counter(program_counter), .wake_reset_pin(wake_reset_pin),
        .wake_power_cycle(wake_power_cycle), .wake_io(wake_io), .wake_rtc(wake_rtc),
        .entry_count(entry_count));

    // ********
    // Shared tasks
    // ********
    task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, msg, got, exp);
        end
    endtask : chk

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        if (!w)
            exp_q.push_back(e);
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask : wr

    task rd(input logic [7:0] a, input logic [32:0] e);
        apb(1'b0, a, 32'h0, e);
    endtask : rd

    // Bias left open in levels 2 to 4, so it is masked there
    task chk_gates(input logic [3:0] m, input logic [3:0] c);
        logic       sub;
        logic       osc;
        logic [5:0] e;
        sub = ~c[0] & ~m[3] & ~m[1];
        osc = ~m[1] & (c[1] | (c[3] & sub) | (c[2] & ~m[0]));
        e = {~m[0], ~m[0], ~m[1], sub, osc, osc | c[2] | (c[3] & sub)};
        @(negedge clk);
        chk(32'(gates_bits | {5'h0, m[3]}), 32'(e | {5'h0, m[3]}), "gates");
    endtask : chk_gates

    task pulse(input logic [1:0] s);
        @(posedge clk);
        wake_sel <= s;
        wake_req <= 1'b1;
        @(posedge clk);
        wake_req <= 1'b0;
    endtask : pulse

    task deep(input logic sel35, input logic [1:0] cause);
        int n;
        rtc_enable <= 1'($random(seed));
        wr(lpmc_pkg::ADDR_PWR_MGMT_CTL, {16'h0, lpmc_pkg::PMM_PASSWORD, 8'h00});
        wr(lpmc_pkg::ADDR_PWR_MGMT_CTL, {16'h0, lpmc_pkg::PMM_PASSWORD, 6'h0, sel35, 1'b1});
        wr(lpmc_pkg::ADDR_STATUS_WORD, 32'h0000_00F0);
        repeat (2) @(negedge clk);
        chk(32'(core_supply_en), 32'h0, "supply in deep");
        chk(32'(pin_lock), 32'h1, "pins latched");
        chk(32'(gates_bits), 32'h0, "deep gates");
        chk(32'(rtc_run), 32'(sel35 & rtc_enable), "rtc in deep");
        rd(lpmc_pkg::ADDR_STATUS_WORD, {1'b1, 32'h0});
        if (!sel35) begin
            pulse(2'd3);
            repeat (3) @(negedge clk);
            chk(32'(core_supply_en), 32'h0, "rtc wake refused");
        end
        pulse(cause);
        n = 0;
        while (brownout_reset !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        n = 0;
        while (brownout_reset === 1'b1 && n < 50) begin
            chk(32'(pin_lock), 32'h1, "lock in reset");
            chk(32'(rtc_run), 32'(sel35 & rtc_enable), "rtc in reset");
            @(negedge clk);
            n++;
        end
        chk(32'(n), 32'(BOR), "brownout length");
        chk(32'(core_supply_en), 32'h1, "supply back");
        chk(32'(boot_start_addr), 32'(lpmc_pkg::RESET_VECTOR_ADDR), "boot");
        rd(lpmc_pkg::ADDR_DEEP_SLEEP, {1'b0, 32'h3});
        rd(lpmc_pkg::ADDR_RESET_CAUSE, {17'h0, lpmc_pkg::RESET_CAUSE_DEEP});
        rd(lpmc_pkg::ADDR_RESET_CAUSE, 33'h0);
        rd(lpmc_pkg::ADDR_STATUS_WORD, 33'h0);
        rd(lpmc_pkg::ADDR_PWR_MGMT_CTL, 33'h0);
        wr(lpmc_pkg::ADDR_DEEP_SLEEP, 32'h2);
        @(negedge clk);
        chk(32'(pin_lock), 32'h0, "pins released");
        wr(lpmc_pkg::ADDR_DEEP_SLEEP, 32'h0);
    endtask : deep

    task wrap_up;
        $display("checks %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up

    // ********
    // Clock, monitor, watchdog
    // ********
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (exp_q.size() == 0)
                chk(32'h1, 32'h0, "unexpected read");
            else begin
                mon_e = exp_q.pop_front();
                chk(prdata, mon_e[31:0], "read data");
                chk(32'(pslverr), 32'(mon_e[32]), "read error");
            end
        end
    end

    // Whole run is about 1130 cycles
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        wrap_up();
    end

    // ********
    // Main sequence
    // ********
    initial begin
        seed = 66153;
        {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
        {irq_req, pc_val, wake_req, wake_sel, rtc_enable} = 21'h0;
        err_count = 0;
        check_count = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++)
            rd(8'(i * 4), {1'b0, (i == 5) ? 32'h0000_003C : 32'h0});
        rd(8'h24, {1'b1, 32'h0});
        wr(8'h24, 32'hFFFF_FFFF);
        $display("test reset values done");
        for (int p = 0; p < 6; p++) begin
            for (int c = 0; c < 16; c++) begin
                wr(lpmc_pkg::ADDR_CLK_CFG, 32'(c));
                rd(lpmc_pkg::ADDR_CLK_CFG, {1'b0, 32'(c)});
                wr(lpmc_pkg::ADDR_STATUS_WORD, {24'h0, pats[p], 4'h0});
                chk_gates(pats[p], 4'(c));
            end
        end
        wr(lpmc_pkg::ADDR_CLK_CFG, 32'h0);
        $display("test mode gating done");
        wr(lpmc_pkg::ADDR_STATUS_WORD, 32'h0000_00F8);
        @(posedge clk);
        irq_req <= 1'b1;
        pc_val <= 16'($random(seed));
        @(posedge clk);
        irq_req <= 1'b0;
        @(negedge clk);
        chk(32'(irq_entry), 32'h1, "irq entry");
        @(negedge clk);
        chk(32'(entry_count), 32'h1, "entries");
        rd(lpmc_pkg::ADDR_STATUS_WORD, {1'b0, 32'h40});
        rd(lpmc_pkg::ADDR_STACKED_SW, {1'b0, 32'hF8});
        rd(lpmc_pkg::ADDR_STACKED_PC, {17'h0, pc_val});
        wr(lpmc_pkg::ADDR_STACKED_SW, 32'h18);
        wr(lpmc_pkg::ADDR_CTL_STROBE, 32'h2);
        rd(lpmc_pkg::ADDR_STATUS_WORD, {1'b0, 32'h18});
        chk_gates(4'h1, 4'h0);
        wr(lpmc_pkg::ADDR_CTL_STROBE, 32'h1);
        rd(lpmc_pkg::ADDR_STATUS_WORD, {1'b0, 32'h0});
        rd(lpmc_pkg::ADDR_STACKED_SW, {1'b0, 32'h18});
        rd(lpmc_pkg::ADDR_STACKED_PC, {17'h0, ~pc_val});
        wr(lpmc_pkg::ADDR_STATUS_WORD, 32'h0);
        $display("test interrupt wake done");
        for (int k = 0; k < 4; k++)
            deep(k == 3, 2'(k));
        wr(lpmc_pkg::ADDR_PWR_MGMT_CTL, 32'h1);
        wr(lpmc_pkg::ADDR_STATUS_WORD, 32'h0000_00F0);
        @(negedge clk);
        chk(32'(core_supply_en), 32'h1, "locked regulator");
        wr(lpmc_pkg::ADDR_STATUS_WORD, 32'h0);
        $display("test deep levels done");
        repeat (2) @(posedge clk);
        chk(32'(exp_q.size()), 32'h0, "reads left");
        wrap_up();
    end
endmodule : tb_low_power_mode_control
